// ===== verilog/serdes_pma_core.sv
// digital model of the gigabit pma transceiver with avalon-mm control
//
// Notes on behaviour
// - every reference clock rising edge captures the full 10-bit transmit word
// - captured word goes out serially, bit 0 first, ascending order
// - serial bits go out one per core clock from each reference edge; host keeps reference within 100 ppm
// - loopback on routes own serial transmit stream into receive path
// - loopback on holds serial output at logic 1, positive high, negative low
// - external serial input feeds receive only while loopback is off
// - no input signal, loopback off: signal detect low, all ten received bits forced to one
// - input signal present: signal detect high, stream goes to deserializer
// - first received serial bit of a word lands in bit 0
// - comma found goes high when comma pattern 0011111xxx is received
// - comma found is driven only while comma align enable is set
// - receive section produces two recovered byte clocks with the data
// - byte clocks antiphase, words alternate between them, clock one on comma
// - align enable high realigns to comma; low freezes boundary, comma found low
`timescale 1ns/1ps
`default_nettype none
module serdes_pma_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [serdes_pma_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // host parallel transmit side
  input wire logic tx_ref_clk,
  input wire logic [serdes_pma_pkg::WORD_W-1:0] tx_word,
  // serial line
  output logic serial_out_p,
  output logic serial_out_n,
  input wire logic serial_in,
  input wire logic serial_in_valid,
  input wire logic signal_present,
  // host parallel receive side
  output logic [serdes_pma_pkg::WORD_W-1:0] rx_word,
  output logic rx_clk0,
  output logic rx_clk1,
  output logic comma_found,
  output logic signal_detect
);
  localparam int W = serdes_pma_pkg::WORD_W;

  // synchronisers for pins from outside core_clk
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic [W-1:0] tx_s1_q, tx_s2_q;
  logic [2:0] rx_s1_q, rx_s2_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      tx_s1_q <= '0;
      tx_s2_q <= '0;
      rx_s1_q <= 3'h0;
      rx_s2_q <= 3'h0;
    end else begin
      ref_s1_q <= tx_ref_clk;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      tx_s1_q <= tx_word;
      tx_s2_q <= tx_s1_q;
      rx_s1_q <= {signal_present, serial_in_valid, serial_in};
      rx_s2_q <= rx_s1_q;
    end
  end

  // control registers
  logic [1:0] control_q;
  logic [serdes_pma_pkg::EV_W-1:0] int_status_q, int_mask_q;
  wire loop_en = control_q[serdes_pma_pkg::CTL_LOOPBACK_BIT];
  wire align_en = control_q[serdes_pma_pkg::CTL_ALIGN_BIT];

  // ---------------- transmit ----------------
  logic [W-1:0] tx_hold_q, tx_shift_q;
  logic [3:0] tx_cnt_q;
  logic tx_load_q, tx_active_q;
  logic out_p_q, out_n_q;
  wire ref_rise = ref_s2_q & ~ref_s3_q;
  wire tx_last = tx_cnt_q == serdes_pma_pkg::BIT_LAST;

  // holding register; the shifter loads it one cycle later
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_hold_q <= '0;
      tx_load_q <= 1'b0;
    end else begin
      tx_load_q <= ref_rise;
      if (ref_rise) tx_hold_q <= tx_s2_q;
    end
  end

  // bit timing restarts at each reference edge, one bit per core cycle;
  // a reference faster than ten core cycles would cut words short
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_shift_q <= '0;
      tx_cnt_q <= serdes_pma_pkg::BIT_FIRST;
      tx_active_q <= 1'b0;
    end else if (tx_load_q) begin
      tx_shift_q <= tx_hold_q;
      tx_cnt_q <= serdes_pma_pkg::BIT_FIRST;
      tx_active_q <= 1'b1;
    end else if (tx_active_q) begin
      tx_shift_q <= {1'b0, tx_shift_q[W-1:1]};
      tx_cnt_q <= tx_cnt_q + 4'h1;
      tx_active_q <= ~tx_last;
    end
  end

  // line driver: idle and loopback both sit at logic 1
  wire line_bit = tx_active_q ? tx_shift_q[0] : 1'b1;
  wire out_p_d = loop_en ? 1'b1 : line_bit;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_p_q <= 1'b1;
      out_n_q <= 1'b0;
    end else begin
      out_p_q <= out_p_d;
      out_n_q <= ~out_p_d;
    end
  end

  // ---------------- receive ----------------
  serdes_pma_pkg::rx_state_t rx_state_q, rx_state_d;
  logic [W-1:0] rx_shift_q, rx_word_q;
  logic [3:0] rx_cnt_q;
  logic comma_q, sigdet_q, clk0_q, clk1_q, sel_q, pend_q, pend_sel_q;

  // source select: own stream in loopback, pins otherwise
  wire rx_bit = loop_en ? tx_shift_q[0] : rx_s2_q[0];
  wire rx_valid = loop_en ? tx_active_q : rx_s2_q[1];
  wire sig_ok = loop_en | rx_s2_q[2];
  wire [W-1:0] rx_window = {rx_bit, rx_shift_q[W-1:1]};
  wire is_comma = (rx_window & serdes_pma_pkg::COMMA_MASK) == serdes_pma_pkg::COMMA_VALUE;
  wire comma_take = align_en & is_comma;
  wire bit_take = sig_ok & rx_valid;
  wire word_end = rx_cnt_q == serdes_pma_pkg::BIT_LAST;
  wire word_evt = bit_take & (word_end | comma_take);
  wire comma_evt = bit_take & comma_take;
  wire clk_sel = comma_take | ~sel_q;

  // deserializer and word boundary; comma restarts the count
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_shift_q <= '0;
      rx_cnt_q <= serdes_pma_pkg::BIT_FIRST;
    end else if (!sig_ok) begin
      rx_cnt_q <= serdes_pma_pkg::BIT_FIRST;
    end else if (bit_take) begin
      rx_shift_q <= rx_window;
      rx_cnt_q <= word_evt ? serdes_pma_pkg::BIT_FIRST : rx_cnt_q + 4'h1;
    end
  end

  // presented word, signal detect and comma flag
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_word_q <= serdes_pma_pkg::WORD_RESET;
      sigdet_q <= 1'b0;
      comma_q <= 1'b0;
    end else begin
      sigdet_q <= sig_ok;
      if (!sig_ok) rx_word_q <= serdes_pma_pkg::LOS_WORD;
      else if (word_evt) rx_word_q <= rx_window;
      if (!align_en || !sig_ok) comma_q <= 1'b0;
      else if (word_evt) comma_q <= comma_take;
    end
  end

  // recovered byte clocks: data first, chosen clock rises one cycle later;
  // a clock already high is dropped for one cycle so the comma still gets an edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clk0_q <= 1'b0;
      clk1_q <= 1'b0;
      sel_q <= 1'b0;
      pend_q <= 1'b0;
      pend_sel_q <= 1'b0;
    end else begin
      pend_q <= word_evt & sig_ok;
      if (word_evt && sig_ok) begin
        sel_q <= clk_sel;
        pend_sel_q <= clk_sel;
        if (clk_sel) clk1_q <= 1'b0;
        else clk0_q <= 1'b0;
      end else if (pend_q) begin
        clk1_q <= pend_sel_q;
        clk0_q <= ~pend_sel_q;
      end
    end
  end

  // link state for status readback
  always_comb begin
    rx_state_d = rx_state_q;
    unique case (rx_state_q)
      serdes_pma_pkg::RX_LOS: if (sig_ok) rx_state_d = serdes_pma_pkg::RX_ACQUIRE;
      serdes_pma_pkg::RX_ACQUIRE: if (comma_evt) rx_state_d = serdes_pma_pkg::RX_ALIGNED;
      serdes_pma_pkg::RX_ALIGNED: rx_state_d = serdes_pma_pkg::RX_ALIGNED;
      default: rx_state_d = serdes_pma_pkg::RX_LOS;
    endcase
    if (!sig_ok) rx_state_d = serdes_pma_pkg::RX_LOS;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) rx_state_q <= serdes_pma_pkg::RX_LOS;
    else rx_state_q <= rx_state_d;
  end

  // ---------------- register bus ----------------
  logic wait_q, irq_q;
  logic [31:0] rdata_q;
  wire req = avs_read | avs_write;
  wire wr_now = avs_write & ~wait_q;
  wire sel_control = avs_address == serdes_pma_pkg::OFF_CONTROL;
  wire sel_int_status = avs_address == serdes_pma_pkg::OFF_INT_STATUS;
  wire sel_int_mask = avs_address == serdes_pma_pkg::OFF_INT_MASK;
  wire [serdes_pma_pkg::EV_W-1:0] events = {sigdet_q & ~sig_ok, ~sigdet_q & sig_ok, comma_evt};
  wire [serdes_pma_pkg::EV_W-1:0] ev_order = {events[0], events[1], events[2]};
  wire [serdes_pma_pkg::EV_W-1:0] ev_vec;
  assign ev_vec[serdes_pma_pkg::EV_COMMA_BIT] = ev_order[2];
  assign ev_vec[serdes_pma_pkg::EV_LOS_BIT] = ev_order[0];
  assign ev_vec[serdes_pma_pkg::EV_SIGNAL_BIT] = ev_order[1];
  wire [serdes_pma_pkg::EV_W-1:0] w1c = (wr_now & sel_int_status) ?
    avs_writedata[serdes_pma_pkg::EV_W-1:0] : '0;
  // set wins over a clear in the same cycle
  wire [serdes_pma_pkg::EV_W-1:0] int_status_d = (int_status_q & ~w1c) | ev_vec;
  wire [31:0] rd_mux =
    (avs_address == serdes_pma_pkg::OFF_CONTROL) ? {30'h0, control_q} :
    (avs_address == serdes_pma_pkg::OFF_STATUS) ? {29'h0, rx_state_q, sigdet_q} :
    (avs_address == serdes_pma_pkg::OFF_INT_STATUS) ? {29'h0, int_status_q} :
    (avs_address == serdes_pma_pkg::OFF_INT_MASK) ? {29'h0, int_mask_q} :
    (avs_address == serdes_pma_pkg::OFF_RX_WORD) ? {22'h0, rx_word_q} : 32'h0;

  // one wait cycle per request, answer on the second cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      control_q <= serdes_pma_pkg::CONTROL_RESET;
      int_status_q <= serdes_pma_pkg::EV_RESET;
      int_mask_q <= serdes_pma_pkg::EV_RESET;
      irq_q <= 1'b0;
    end else begin
      wait_q <= ~(req & wait_q);
      if (avs_read && wait_q) rdata_q <= rd_mux;
      if (wr_now && sel_control) control_q <= avs_writedata[1:0];
      if (wr_now && sel_int_mask) int_mask_q <= avs_writedata[serdes_pma_pkg::EV_W-1:0];
      int_status_q <= int_status_d;
      irq_q <= |(int_status_d & int_mask_q);
    end
  end

  // outputs straight from flops
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq = irq_q;
  assign serial_out_p = out_p_q;
  assign serial_out_n = out_n_q;
  assign rx_word = rx_word_q;
  assign rx_clk0 = clk0_q;
  assign rx_clk1 = clk1_q;
  assign comma_found = comma_q;
  assign signal_detect = sigdet_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  tx_capture_a: assert property (ref_rise |-> ##2 tx_shift_q == $past(tx_s2_q, 2))
    else $error("transmit word not captured on reference edge");
  lsb_first_a: assert property ((tx_load_q && !loop_en) ##1 !loop_en |=>
    out_p_q == $past(tx_hold_q[0], 2)) else $error("bit 0 not sent first");
  loop_static_a: assert property (loop_en |=> out_p_q && !out_n_q)
    else $error("line not static one in loopback");
  loop_route_a: assert property (loop_en && tx_active_q |=>
    rx_shift_q[W-1] == $past(tx_shift_q[0])) else $error("loopback source wrong");
  los_ones_a: assert property (!sig_ok |=>
    rx_word_q == serdes_pma_pkg::LOS_WORD && !sigdet_q)
    else $error("loss of signal not forcing ones");
  sigdet_on_a: assert property (sig_ok ##1 sig_ok |-> sigdet_q)
    else $error("signal detect low with signal");
  comma_gate_a: assert property (!align_en |=> !comma_q)
    else $error("comma found while disabled");
  comma_bit0_a: assert property ($rose(comma_q) |->
    (rx_word_q & serdes_pma_pkg::COMMA_MASK) == serdes_pma_pkg::COMMA_VALUE)
    else $error("comma not at bit 0");
  comma_clk1_a: assert property (word_evt && sig_ok && comma_take |->
    ##2 clk1_q && !clk0_q) else $error("comma word not on clock one");
  clk_anti_a: assert property (!(clk0_q && clk1_q))
    else $error("byte clocks high together");
  bus_answer_a: assert property (req && wait_q |=> !wait_q)
    else $error("bus answer late");

  comma_seen_c: cover property (comma_evt ##[1:40] comma_evt);
  loop_run_c: cover property (loop_en && comma_evt);
  los_c: cover property (sigdet_q ##1 !sigdet_q);
  irq_c: cover property (!irq_q ##1 irq_q);
endmodule
`default_nettype wire

// ===== verilog/serdes_pma_pkg.sv
// shared constants for the gigabit pma transceiver core
package serdes_pma_pkg;
  // word geometry
  localparam int WORD_W = 10;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  // comma 0011111xxx in line order; first received bit sits in bit 0
  localparam logic [9:0] COMMA_MASK = 10'h07f;
  localparam logic [9:0] COMMA_VALUE = 10'h07c;
  localparam logic [9:0] LOS_WORD = 10'h3ff;
  localparam logic [9:0] WORD_RESET = 10'h3ff;
  // register byte offsets
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CONTROL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_INT_STATUS = 5'h08;
  localparam logic [4:0] OFF_INT_MASK = 5'h0c;
  localparam logic [4:0] OFF_RX_WORD = 5'h10;
  // control fields
  localparam int CTL_LOOPBACK_BIT = 0;
  localparam int CTL_ALIGN_BIT = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  // interrupt event fields
  localparam int EV_W = 3;
  localparam int EV_COMMA_BIT = 0;
  localparam int EV_LOS_BIT = 1;
  localparam int EV_SIGNAL_BIT = 2;
  localparam logic [2:0] EV_RESET = 3'h0;
  // clock rate of core_clk
  localparam int CORE_CLK_MHZ = 250;
  // receive link state, gray along los -> acquire -> aligned
  typedef enum logic [1:0] {
    RX_LOS = 2'b00,
    RX_ACQUIRE = 2'b01,
    RX_ALIGNED = 2'b11
  } rx_state_t;
endpackage

// ===== bench/serial_far_end.sv
// remote transceiver model: sends words bit by bit into the core's serial input
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
  // clock
  input wire logic core_clk,
  // serial line towards the core
  output logic serial_in,
  output logic serial_in_valid,
  output logic signal_present
);
  bit bit_q[$];
  // level asked for by the bench; reaches the pin at the next edge
  bit present_q = 1'b1;
  // queue a word in line order
  task automatic push_word(input logic [9:0] v);
    for (int i = 0; i < 10; i++) bit_q.push_back(v[i]);
  endtask
  task automatic set_present(input logic b);
    @(posedge core_clk);
    present_q <= b;
  endtask
  // idle line toggles every cycle so a stale bit never looks valid
  always @(posedge core_clk) begin
    signal_present <= present_q;
    serial_in_valid <= bit_q.size() > 0;
    if (bit_q.size() > 0) serial_in <= bit_q.pop_front();
    else serial_in <= ~serial_in;
  end
endmodule
`default_nettype wire

// ===== bench/test_gigabit_serdes_pma_core.sv
// self-checking bench for the pma core: bus, transmit, receive, loss of signal
`timescale 1ns/1ps
`default_nettype none
module test_gigabit_serdes_pma_core;
  logic core_clk, reset, avs_read, avs_write, tx_ref_clk, avs_waitrequest, irq;
  logic serial_out_p, serial_out_n, serial_in, serial_in_valid, signal_present;
  logic rx_clk0, rx_clk1, comma_found, signal_detect, c0_q, c1_q;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [9:0] tx_word, rx_word, v, w;
  logic [9:0] exp_q[$];
  int error_cnt, comparisons, cyc, seed, n, tx_mode;
  bit loop_on, align_on, synced, last1;
  serdes_pma_core u_dut (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .tx_ref_clk, .tx_word,
    .serial_out_p, .serial_out_n, .serial_in, .serial_in_valid, .signal_present,
    .rx_word, .rx_clk0, .rx_clk1, .comma_found, .signal_detect);
  serial_far_end u_far (.core_clk, .serial_in, .serial_in_valid, .signal_present);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // reference runs free at an odd phase to the core clock
  initial begin
    tx_ref_clk = 1'b0;
    #1.3;
    forever #24 tx_ref_clk = ~tx_ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // hold the request until the answer; only the run's timeout ends a hang
    do @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_sd(input logic lvl);
    n = 0;
    while (signal_detect !== lvl && n < 10) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  // data words keep bits 4 and 9 low: no run of five ones, so no false comma
  always @(negedge tx_ref_clk) begin
    @(posedge core_clk);
    if (tx_mode == 1) tx_word <= serdes_pma_pkg::COMMA_VALUE;
    else if (tx_mode == 2) tx_word <= 10'($random(seed)) & 10'h1ee;
    else tx_word <= 10'($random(seed)) & 10'h1ef;
  end
  always @(posedge tx_ref_clk) if (loop_on) exp_q.push_back(tx_word);
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // reference receiver: compare every presented word once aligned
  always @(posedge core_clk) begin
    c0_q <= rx_clk0;
    c1_q <= rx_clk1;
    if ((rx_clk0 && !c0_q) || (rx_clk1 && !c1_q)) begin
      check(rx_clk0 & rx_clk1, 1'b0);
      if (!align_on) check(comma_found, 1'b0);
      else if (comma_found === 1'b1) begin
        check(rx_clk1, 1'b1);
        check(rx_word & serdes_pma_pkg::COMMA_MASK, serdes_pma_pkg::COMMA_VALUE);
        while (exp_q.size() > 0 && exp_q[0] !== serdes_pma_pkg::COMMA_VALUE) void'(exp_q.pop_front());
        if (exp_q.size() > 0) check(rx_word, exp_q.pop_front());
        synced = 1;
        last1 = 1'b1;
      end else if (synced) begin
        // aligned words alternate between the two byte clocks
        check(rx_clk1, !last1);
        last1 = rx_clk1;
        if (exp_q.size() > 0) check(rx_word, exp_q.pop_front());
      end
    end
  end
  initial begin
    seed = 86311;
    reset = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    // register values after reset; the line comes up, so signal regained is flagged
    bus(0, serdes_pma_pkg::OFF_CONTROL, 32'h0);
    check(rd, 32'(serdes_pma_pkg::CONTROL_RESET));
    bus(0, serdes_pma_pkg::OFF_RX_WORD, 32'h0);
    check(rd, 32'(serdes_pma_pkg::WORD_RESET));
    bus(0, serdes_pma_pkg::OFF_STATUS, 32'h0);
    check(rd, {29'h0, serdes_pma_pkg::RX_ACQUIRE, 1'b1});
    bus(0, serdes_pma_pkg::OFF_INT_STATUS, 32'h0);
    check(rd, 32'h1 << serdes_pma_pkg::EV_SIGNAL_BIT);
    // wire order of one transmitted word, bit 0 low to mark its start
    tx_mode = 2;
    @(negedge tx_ref_clk);
    @(posedge tx_ref_clk);
    v = tx_word;
    tx_mode = 0;
    repeat (4) @(posedge core_clk);
    wait_sd(1'b1);
    n = 0;
    while (serial_out_p !== 1'b0 && n < 12) begin
      @(posedge core_clk);
      n++;
    end
    w = '0;
    for (int i = 1; i < 10; i++) begin
      @(posedge core_clk);
      w[i] = serial_out_p;
    end
    check(w, v);
    // external receive with alignment on
    bus(1, serdes_pma_pkg::OFF_INT_MASK, 32'h2);
    bus(1, serdes_pma_pkg::OFF_CONTROL, 32'h2);
    align_on = 1;
    exp_q.push_back(serdes_pma_pkg::COMMA_VALUE);
    u_far.push_word(serdes_pma_pkg::COMMA_VALUE);
    repeat (6) begin
      v = 10'($random(seed)) & 10'h1ef;
      exp_q.push_back(v);
      u_far.push_word(v);
    end
    repeat (100) @(posedge core_clk);
    check(exp_q.size(), 0);
    bus(0, serdes_pma_pkg::OFF_STATUS, 32'h0);
    check(rd, {29'h0, serdes_pma_pkg::RX_ALIGNED, 1'b1});
    // loopback: far commas must be ignored, own stream must come back
    synced = 0;
    bus(1, serdes_pma_pkg::OFF_CONTROL, 32'h3);
    loop_on = 1;
    repeat (6) u_far.push_word(serdes_pma_pkg::COMMA_VALUE);
    tx_mode = 1;
    repeat (24) @(posedge core_clk);
    tx_mode = 0;
    repeat (120) @(posedge core_clk);
    check({serial_out_p, serial_out_n}, 2'b10);
    check(exp_q.size() < 3, 1'b1);
    // alignment off: commas seen but never flagged
    bus(1, serdes_pma_pkg::OFF_CONTROL, 32'h0);
    {loop_on, align_on, synced} = '0;
    exp_q.delete();
    repeat (4) u_far.push_word(serdes_pma_pkg::COMMA_VALUE);
    repeat (60) @(posedge core_clk);
    // loss of signal with a masked and an unmasked event
    bus(1, serdes_pma_pkg::OFF_INT_STATUS, 32'h7);
    check(irq, 1'b0);
    u_far.set_present(1'b0);
    wait_sd(1'b0);
    check(signal_detect, 1'b0);
    check(rx_word, serdes_pma_pkg::LOS_WORD);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b1);
    bus(1, serdes_pma_pkg::OFF_INT_STATUS, 32'h2);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b0);
    u_far.set_present(1'b1);
    wait_sd(1'b1);
    check(signal_detect, 1'b1);
    bus(0, serdes_pma_pkg::OFF_INT_STATUS, 32'h0);
    check(rd & 32'h6, 32'h4);
    check(irq, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
